// file: hw/scs_defines.svh
// Offsets, field positions, channel keep masks and timing counts of the sequencer
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Register byte offsets
`define SCS_OFF_CTRL    8'h00
`define SCS_OFF_INTEG   8'h04
`define SCS_OFF_LED     8'h08
`define SCS_OFF_STATUS  8'h0c
`define SCS_OFF_CH0     8'h10
`define SCS_OFF_CH5     8'h24

// Control register fields
`define SCS_CTRL_TRIG   0
`define SCS_CTRL_RDY    1
`define SCS_CTRL_MODE_L 2
`define SCS_CTRL_MODE_H 3
`define SCS_CTRL_IRQEN  6

// Channels kept per group mode (bit n is channel n, 610 nm first)
`define SCS_KEEP_G1     6'h1e
`define SCS_KEEP_G2     6'h2d
`define SCS_KEEP_ALL    6'h3f

// Timing
`define SCS_CLK_MHZ     200
`define SCS_TICK_US     100
`define SCS_TICK_CYC    (`SCS_TICK_US * `SCS_CLK_MHZ)
`define SCS_MIN_IT_US   2800
`define SCS_MIN_IT      8'((`SCS_MIN_IT_US + `SCS_TICK_US - 1) / `SCS_TICK_US)
`define SCS_RESET_MS    100
`define SCS_RESET_CYC   (`SCS_RESET_MS * 1000 * `SCS_CLK_MHZ)
`define SCS_FLASH_MS    500
`define SCS_FLASH_CYC   (`SCS_FLASH_MS * 1000 * `SCS_CLK_MHZ)

`define SCS_RESP_OKAY   2'b00
`define SCS_RESP_SLVERR 2'b10

`endif

// file: hw/scs_pkg.sv
// Types shared by the spectral conversion sequencer
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_MODE_G1   = 2'b00,
    SCS_MODE_G2   = 2'b01,
    SCS_MODE_BOTH = 2'b10,
    SCS_MODE_ONE  = 2'b11
  } scs_mode_t;

  typedef enum logic [1:0] {
    SCS_ST_IDLE  = 2'b00,
    SCS_ST_CONV1 = 2'b01,
    SCS_ST_CONV2 = 2'b10
  } scs_state_t;

  // Four 16-bit results of one photodiode group
  typedef struct packed {
    logic [15:0] d3;
    logic [15:0] d2;
    logic [15:0] d1;
    logic [15:0] d0;
  } scs_grp_t;

  typedef struct packed {
    logic       en;
    logic [1:0] isel;
  } scs_led_t;

endpackage

// file: hw/scs_top.sv
// Spectral conversion sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`include "scs_defines.svh"

module scs_top
  import scs_pkg::*;
#(
  parameter int TICK_CYC  = `SCS_TICK_CYC,
  parameter int RESET_CYC = `SCS_RESET_CYC,
  parameter int FLASH_CYC = `SCS_FLASH_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        external_reset_low_i,
  input  wire logic        fw_loading_i,
  input  wire scs_grp_t    adc_grp1_i,
  input  wire scs_grp_t    adc_grp2_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             irq_line_n_o,
  output scs_state_t       conv_state_o,
  output scs_led_t         indicator_led_sink_o,
  output scs_led_t         illumination_led_sink_o
);

  //--------------------------------------------------------------
  // Reset
  //--------------------------------------------------------------
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic [24:0] ext_cnt_r;
  logic        ext_fire_r;
  logic        srst;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
    end else begin
      ext_s1_r <= external_reset_low_i;
      ext_s2_r <= ext_s1_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || ext_s2_r) begin
      ext_cnt_r  <= 25'h0;
      ext_fire_r <= 1'b0;
    end else if (ext_cnt_r == 25'(RESET_CYC)) begin
      ext_fire_r <= 1'b1;
    end else begin
      ext_cnt_r <= ext_cnt_r + 25'h1;
    end
  end

  assign srst = !rst_n_i || ext_fire_r;

  //--------------------------------------------------------------
  // AXI4-Lite write channels
  //--------------------------------------------------------------
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_hs;
  logic        w_hs;
  logic        do_wr;
  logic        wr_ok;
  logic        wr_ctrl;
  logic        wr_it;
  logic        wr_led;

  assign aw_hs   = s_axi_awvalid_i && awready_r;
  assign w_hs    = s_axi_wvalid_i && wready_r;
  assign do_wr   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok   = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r <= `SCS_OFF_CH5);
  assign wr_ctrl = do_wr && aw_addr_r == `SCS_OFF_CTRL && w_strb_r[0];
  assign wr_it   = do_wr && aw_addr_r == `SCS_OFF_INTEG && w_strb_r[0];
  assign wr_led  = do_wr && aw_addr_r == `SCS_OFF_LED && w_strb_r[0];

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SCS_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
        awready_r <= 1'b0;
      end
      if (w_hs) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
        wready_r <= 1'b0;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_i) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------
  // Control registers
  //--------------------------------------------------------------
  scs_mode_t  mode_r;
  scs_mode_t  wmode;
  logic       trig_r;
  logic       irq_en_r;
  logic [7:0] integ_r;
  scs_led_t   ind_r;
  scs_led_t   ill_r;
  logic       restart;
  logic       commit;

  assign wmode   = scs_mode_t'(w_data_r[`SCS_CTRL_MODE_H:`SCS_CTRL_MODE_L]);
  // Mode change or fresh one-shot request restarts the sequence
  assign restart = wr_ctrl && (wmode != mode_r || wmode == SCS_MODE_ONE);

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      mode_r   <= SCS_MODE_ONE;
      trig_r   <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_r   <= wmode;
        irq_en_r <= w_data_r[`SCS_CTRL_IRQEN];
        trig_r   <= (wmode == SCS_MODE_ONE);
      end else if (commit && mode_r == SCS_MODE_ONE) begin
        trig_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      integ_r <= `SCS_MIN_IT;
    end else if (wr_it) begin
      integ_r <= (w_data_r[7:0] < `SCS_MIN_IT) ? `SCS_MIN_IT
                                               : w_data_r[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      ind_r <= '0;
      ill_r <= '0;
    end else if (wr_led) begin
      ind_r <= {w_data_r[0], w_data_r[2:1]};
      ill_r <= {w_data_r[3], w_data_r[5:4]};
    end
  end

  //--------------------------------------------------------------
  // Conversion sequencer
  //--------------------------------------------------------------
  scs_state_t  state_r;
  logic [15:0] pre_cnt_r;
  logic [7:0]  tick_cnt_r;
  logic        commit_req_r;
  logic        pend_r;
  logic        tick_p;
  logic        end_conv;
  logic        produces;
  logic        start_ok;
  logic        ch_rd;

  assign tick_p   = pre_cnt_r == 16'(TICK_CYC - 1);
  assign end_conv = state_r != SCS_ST_IDLE && tick_p &&
                    tick_cnt_r >= integ_r - 8'h01;
  // Mode 0 completes after group 1; all others after group 2
  assign produces = (state_r == SCS_ST_CONV2) ||
                    (state_r == SCS_ST_CONV1 && mode_r == SCS_MODE_G1);
  assign start_ok = mode_r != SCS_MODE_ONE ||
                    (trig_r && !commit_req_r && !pend_r);
  // Commit is held off one cycle by a result read in flight
  assign commit   = (commit_req_r || pend_r) && !ch_rd;

  always_ff @(posedge ref_clk_i) begin
    if (srst || restart) begin
      state_r      <= SCS_ST_IDLE;
      commit_req_r <= 1'b0;
    end else begin
      commit_req_r <= end_conv && produces;
      case (state_r)
        SCS_ST_IDLE: begin
          if (start_ok) begin
            state_r <= (mode_r == SCS_MODE_G2) ? SCS_ST_CONV2
                                               : SCS_ST_CONV1;
          end
        end
        SCS_ST_CONV1: begin
          if (end_conv) begin
            state_r <= (mode_r == SCS_MODE_G1) ? SCS_ST_CONV1
                                               : SCS_ST_CONV2;
          end
        end
        SCS_ST_CONV2: begin
          if (end_conv) begin
            if (mode_r == SCS_MODE_G2) begin
              state_r <= SCS_ST_CONV2;
            end else if (mode_r == SCS_MODE_BOTH) begin
              state_r <= SCS_ST_CONV1;
            end else begin
              state_r <= SCS_ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= SCS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst || restart || state_r == SCS_ST_IDLE || end_conv) begin
      pre_cnt_r  <= 16'h0;
      tick_cnt_r <= 8'h0;
    end else if (tick_p) begin
      pre_cnt_r  <= 16'h0;
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end else begin
      pre_cnt_r <= pre_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst || restart) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= (commit_req_r || pend_r) && ch_rd;
    end
  end

  //--------------------------------------------------------------
  // Result buffers
  //--------------------------------------------------------------
  logic [15:0] shadow_r [6];
  logic [15:0] res_r    [6];
  logic [5:0]  keep;

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      for (int i = 0; i < 6; i++) begin
        shadow_r[i] <= 16'h0;
      end
    end else if (end_conv && state_r == SCS_ST_CONV1) begin
      shadow_r[1] <= adc_grp1_i.d0;
      shadow_r[2] <= adc_grp1_i.d1;
      shadow_r[3] <= adc_grp1_i.d2;
      shadow_r[4] <= adc_grp1_i.d3;
    end else if (end_conv) begin
      shadow_r[0] <= adc_grp2_i.d0;
      shadow_r[5] <= adc_grp2_i.d3;
      if (mode_r == SCS_MODE_G2) begin
        shadow_r[2] <= adc_grp2_i.d1;
        shadow_r[3] <= adc_grp2_i.d2;
      end
    end
  end

  always_comb begin
    if (mode_r == SCS_MODE_G1) begin
      keep = `SCS_KEEP_G1;
    end else if (mode_r == SCS_MODE_G2) begin
      keep = `SCS_KEEP_G2;
    end else begin
      keep = `SCS_KEEP_ALL;
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_res
    always_ff @(posedge ref_clk_i) begin
      if (srst) begin
        res_r[g] <= 16'h0;
      end else if (commit) begin
        res_r[g] <= keep[g] ? shadow_r[g] : 16'h0;
      end
    end
  end

  //--------------------------------------------------------------
  // Ready flag and interrupt line
  //--------------------------------------------------------------
  logic ready_r;
  logic irq_n_r;
  logic rd_ctrl;

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      ready_r <= 1'b0;
    end else if (commit) begin
      ready_r <= 1'b1;
    end else if (ch_rd) begin
      ready_r <= 1'b0;
    end
  end

  // Stays low until a control read, even across later results
  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      irq_n_r <= 1'b1;
    end else if (commit && irq_en_r) begin
      irq_n_r <= 1'b0;
    end else if (rd_ctrl) begin
      irq_n_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // AXI4-Lite read channels
  //--------------------------------------------------------------
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic        ar_hs;
  logic        fw_s2_r;
  logic [2:0]  ch_idx;

  assign ar_hs   = s_axi_arvalid_i && arready_r;
  assign rd_ok   = (s_axi_araddr_i[1:0] == 2'h0) &&
                   (s_axi_araddr_i <= `SCS_OFF_CH5);
  assign rd_ctrl = ar_hs && s_axi_araddr_i == `SCS_OFF_CTRL;
  assign ch_rd   = ar_hs && rd_ok && s_axi_araddr_i >= `SCS_OFF_CH0;
  assign ch_idx  = 3'((s_axi_araddr_i - `SCS_OFF_CH0) >> 2);

  always_comb begin
    rd_mux = 32'h0;
    if (s_axi_araddr_i == `SCS_OFF_CTRL) begin
      rd_mux[`SCS_CTRL_TRIG]                      = trig_r;
      rd_mux[`SCS_CTRL_RDY]                       = ready_r;
      rd_mux[`SCS_CTRL_MODE_H:`SCS_CTRL_MODE_L]   = mode_r;
      rd_mux[`SCS_CTRL_IRQEN]                     = irq_en_r;
    end else if (s_axi_araddr_i == `SCS_OFF_INTEG) begin
      rd_mux[7:0] = integ_r;
    end else if (s_axi_araddr_i == `SCS_OFF_LED) begin
      rd_mux[5:0] = {ill_r.isel, ill_r.en, ind_r.isel, ind_r.en};
    end else if (s_axi_araddr_i == `SCS_OFF_STATUS) begin
      rd_mux[3:0] = {fw_s2_r, pend_r || commit_req_r, state_r};
    end else if (ch_rd) begin
      rd_mux[15:0] = res_r[ch_idx];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `SCS_RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // LED sinks
  //--------------------------------------------------------------
  logic        fw_s1_r;
  logic [26:0] fl_cnt_r;
  logic        flash_r;
  scs_led_t    ind_o_r;
  scs_led_t    ill_o_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      fw_s1_r <= 1'b0;
      fw_s2_r <= 1'b0;
    end else begin
      fw_s1_r <= fw_loading_i;
      fw_s2_r <= fw_s1_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst || !fw_s2_r) begin
      fl_cnt_r <= 27'h0;
      flash_r  <= 1'b1;
    end else if (fl_cnt_r == 27'(FLASH_CYC - 1)) begin
      fl_cnt_r <= 27'h0;
      flash_r  <= ~flash_r;
    end else begin
      fl_cnt_r <= fl_cnt_r + 27'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      ind_o_r <= '0;
      ill_o_r <= '0;
    end else begin
      ind_o_r <= fw_s2_r ? {flash_r, ind_r.isel} : ind_r;
      ill_o_r <= ill_r;
    end
  end

  assign s_axi_awready_o         = awready_r;
  assign s_axi_wready_o          = wready_r;
  assign s_axi_bvalid_o          = bvalid_r;
  assign s_axi_bresp_o           = bresp_r;
  assign s_axi_arready_o         = arready_r;
  assign s_axi_rvalid_o          = rvalid_r;
  assign s_axi_rdata_o           = rdata_r;
  assign s_axi_rresp_o           = rresp_r;
  assign irq_line_n_o            = irq_n_r;
  assign conv_state_o            = state_r;
  assign indicator_led_sink_o    = ind_o_r;
  assign illumination_led_sink_o = ill_o_r;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst);

  property p_one_clear;
    commit && mode_r == SCS_MODE_ONE && !wr_ctrl |=> !trig_r && ready_r;
  endproperty
  a_one_clear: assert property (p_one_clear)
    else $error("trigger not cleared with ready");

  property p_irq_low;
    commit && irq_en_r |=> !irq_line_n_o ##1 !irq_line_n_o || $past(rd_ctrl);
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("irq line not pulled low on ready");

  property p_irq_rel;
    rd_ctrl && !commit |=> irq_line_n_o;
  endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("irq line not released by control read");

  property p_rd_clr;
    ch_rd |=> !ready_r;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("ready flag not cleared by result read");

  property p_defer;
    commit_req_r && ch_rd && !restart |=> commit;
  endproperty
  a_defer: assert property (p_defer)
    else $error("deferred result load lost");

  property p_zero_g1;
    commit && mode_r == SCS_MODE_G1 |=> res_r[0] == 16'h0 && res_r[5] == 16'h0;
  endproperty
  a_zero_g1: assert property (p_zero_g1)
    else $error("mode 0 left group 2 channels nonzero");

  property p_zero_g2;
    commit && mode_r == SCS_MODE_G2 |=> res_r[1] == 16'h0 && res_r[4] == 16'h0;
  endproperty
  a_zero_g2: assert property (p_zero_g2)
    else $error("mode 1 left group 1 channels nonzero");

  property p_min_it;
    integ_r >= `SCS_MIN_IT;
  endproperty
  a_min_it: assert property (p_min_it)
    else $error("integration period below minimum");

  property p_no_start;
    state_r == SCS_ST_IDLE && mode_r == SCS_MODE_ONE && !trig_r
      |=> state_r == SCS_ST_IDLE;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("one-shot conversion without trigger");

  property p_hold;
    state_r != SCS_ST_IDLE && !end_conv && !restart |=> $stable(state_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("conversion ended before its period");

  property p_two_periods;
    commit_req_r && mode_r[1] |-> $past(state_r) == SCS_ST_CONV2;
  endproperty
  a_two_periods: assert property (p_two_periods)
    else $error("both-group result ready after one period");

  property p_cont;
    state_r == SCS_ST_IDLE && mode_r != SCS_MODE_ONE && !restart
      |=> state_r != SCS_ST_IDLE;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous mode did not start");

endmodule // scs_top

// file: dv/scs_host.sv
// Host model: AXI4-Lite master reaching the sequencer registers
`timescale 1ns/1ps

module scs_host (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
    {bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end

  // Clamp and mode rewrites are issued by the caller
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (bvalid_i !== 1'b1);
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule // scs_host

// file: dv/spectral_conversion_sequencer_bench.sv
// Self-checking bench of the spectral conversion sequencer
`timescale 1ns/1ps

module spectral_conversion_sequencer_bench;
  import scs_pkg::*;
  localparam int TK = 4;
  localparam int PER = 28 * TK;
  logic        ref_clk_i, rst_n_i, ext_n, fw;
  scs_grp_t    g1, g2;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0]  ws;
  logic [1:0]  br, rr, r;
  logic        awv, awr, wv, wr_, bv, bre, arv, arr, rv, rre, irq;
  scs_state_t  st;
  scs_led_t    ind, ill;
  int          bad_count, check_count, cyc, t0, t, ch[6];

  scs_top #(.TICK_CYC(TK), .RESET_CYC(8), .FLASH_CYC(5)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .external_reset_low_i(ext_n), .fw_loading_i(fw),
    .adc_grp1_i(g1), .adc_grp2_i(g2),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .irq_line_n_o(irq),
    .conv_state_o(st), .indicator_led_sink_o(ind),
    .illumination_led_sink_o(ill));

  scs_host host (
    .clk_i(ref_clk_i), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
    .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr_),
    .bresp_i(br), .bvalid_i(bv), .bready_o(bre), .araddr_o(ara),
    .arvalid_o(arv), .arready_i(arr), .rdata_i(rdat), .rresp_i(rr),
    .rvalid_i(rv), .rready_o(rre));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  task automatic model(input int m);
    for (int i = 0; i < 6; i++) ch[i] = 0;
    if (m != 1) begin
      ch[1] = g1.d0;
      ch[2] = g1.d1;
      ch[3] = g1.d2;
      ch[4] = g1.d3;
    end
    if (m != 0) begin
      ch[0] = g2.d0;
      ch[5] = g2.d3;
    end
    if (m == 1) begin
      ch[2] = g2.d1;
      ch[3] = g2.d2;
    end
  endtask

  task automatic rnd();
    g1 <= {$urandom, $urandom};
    g2 <= {$urandom, $urandom};
  endtask

  task automatic wait_irq(output int tm);
    int n;
    n = 0;
    while (irq !== 1'b0 && n < 800) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(n < 800, 1);
    tm = int'($time / 5);
  endtask

  task automatic rd_ch(input int m);
    model(m);
    for (int i = 0; i < 6; i++) begin
      host.rd(8'h10 + 8'(i * 4), d, r);
      chk(d, ch[i]);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(98));
    {rst_n_i, ext_n, fw, g1, g2} = '0;
    ext_n = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    host.rd(8'h00, d, r);
    chk(d, 32'h0c);
    host.wr(8'h04, 32'h05);
    chk(br, 2'b00);
    host.rd(8'h04, d, r);
    chk(d, 32'h1c);
    host.rd(8'h28, d, r);
    chk(d, 32'h0);
    chk(r, 2'b10);
    host.wr(8'h2c, 32'h0);
    chk(br, 2'b10);
    repeat (150) @(posedge ref_clk_i);
    chk(st, SCS_ST_IDLE);
    for (int k = 0; k < 2; k++) begin
      rnd();
      host.wr(8'h00, 32'h4c);
      t0 = int'($time / 5);
      wait_irq(t);
      chk(t - t0 >= 2 * PER && t - t0 <= 2 * PER + 4, 1);
      host.rd(8'h00, d, r);
      chk(d, 32'h4e);
      repeat (2) @(posedge ref_clk_i);
      chk(irq, 1);
      rd_ch(2);
      host.rd(8'h00, d, r);
      chk(d, 32'h4c);
      chk(st, SCS_ST_IDLE);
    end
    for (int m = 0; m < 3; m++) begin
      host.wr(8'h00, 32'h40 + 32'(m * 4));
      // Release irq left low by the previous mode
      host.rd(8'h00, d, r);
      wait_irq(t0);
      host.rd(8'h00, d, r);
      rnd();
      wait_irq(t);
      chk(t - t0, PER * (m == 2 ? 2 : 1));
      rnd();
      repeat (PER * (m == 2 ? 2 : 1) + 4) @(posedge ref_clk_i);
      chk(irq, 0);
      rd_ch(m);
    end
    repeat (4) begin
      host.wr(8'h08, $urandom);
      repeat (2) @(posedge ref_clk_i);
      chk(ind, {wd[0], wd[2:1]});
      chk(ill, {wd[3], wd[5:4]});
    end
    host.wr(8'h08, 32'h0);
    fw <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    t = 0;
    repeat (20) begin
      @(posedge ref_clk_i);
      t += int'(ind.en);
    end
    chk(t, 10);
    fw <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    chk(ind.en, 0);
    host.wr(8'h04, 32'h28);
    ext_n <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    ext_n <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    host.rd(8'h00, d, r);
    chk(d[6:2], 5'h12);
    ext_n <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    ext_n <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    host.rd(8'h00, d, r);
    chk(d, 32'h0c);
    host.rd(8'h04, d, r);
    chk(d, 32'h1c);
    print_verdict();
  end
endmodule // spectral_conversion_sequencer_bench
